// File: hw/cpse_pkg.sv
// Constants and arithmetic shared by the current and power scaling engine.
package cpse_pkg;

    localparam logic [7:0] ADDR_SETUP = 8'h00;
    localparam logic [7:0] ADDR_SHUNT = 8'h01;
    localparam logic [7:0] ADDR_BUS = 8'h02;
    localparam logic [7:0] ADDR_POWER = 8'h03;
    localparam logic [7:0] ADDR_CURRENT = 8'h04;
    localparam logic [7:0] ADDR_SCALE = 8'h05;

    localparam logic [15:0] SETUP_RST_VAL = 16'h4127;
    localparam logic [15:0] RESULT_RST_VAL = 16'h0000;
    localparam logic [15:0] SCALE_RST_VAL = 16'h0000;
    localparam int SETUP_RESET_BIT = 15;
    localparam int BUS_SIGN_BIT = 15;

    localparam logic signed [32:0] CURRENT_DIVISOR = 33'sh0_0000_0800;
    localparam logic signed [32:0] POWER_DIVISOR = 33'sh0_0000_4E20;
    localparam int POWER_TO_CURRENT_RATIO = 25;
    localparam int BUS_STEP_NV = 1250000;
    localparam int SHUNT_STEP_NV = 2500;
    localparam int RESULT_LATENCY = 3;

    function automatic logic signed [15:0] calc_current(input logic signed [15:0] shunt,
                                                        input logic [15:0] scale);
        logic signed [32:0] prod;
        prod = shunt * $signed({1'b0, scale});
        prod = prod / CURRENT_DIVISOR;
        return prod[15:0];
    endfunction : calc_current

    function automatic logic signed [15:0] calc_power(input logic signed [15:0] cur,
                                                      input logic [15:0] bus);
        logic signed [32:0] prod;
        prod = cur * $signed({1'b0, bus});
        prod = prod / POWER_DIVISOR;
        return prod[15:0];
    endfunction : calc_power

    function automatic logic [15:0] bus_field(input logic [15:0] code);
        return {1'b0, code[BUS_SIGN_BIT-1:0]};
    endfunction : bus_field

endpackage : cpse_pkg

// File: hw/scale_if.sv
// Handshake and operands between the register block and the arithmetic pipeline.
`timescale 1ns/1ns
`default_nettype none
interface scale_if;
    logic start;
    logic signed [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] scale;
    logic done;
    logic signed [15:0] cur;
    logic signed [15:0] pwr;
    modport engine(input start, input shunt, input bus, input scale,
                   output done, output cur, output pwr);
    modport client(output start, output shunt, output bus, output scale,
                   input done, input cur, input pwr);
endinterface : scale_if
`default_nettype wire

// File: hw/scale_mac.sv
// Two-stage pipeline: current from shunt and scale factor, then power.
`timescale 1ns/1ns
`default_nettype none
module scale_mac
    import cpse_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    scale_if.engine sif
);
    logic stage1_r;
    logic signed [15:0] cur1_r;
    logic [15:0] bus1_r;
    logic done_r;
    logic signed [15:0] cur2_r;
    logic signed [15:0] pwr_r;

    // First stage forms the current code.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            stage1_r <= 1'b0;
            cur1_r <= '0;
            bus1_r <= '0;
        end else begin
            stage1_r <= sif.start;
            if (sif.start) begin
                cur1_r <= calc_current(sif.shunt, sif.scale);
                bus1_r <= sif.bus;
            end
        end
    end

    // Second stage forms the power code from the truncated current.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            done_r <= 1'b0;
            cur2_r <= '0;
            pwr_r <= '0;
        end else begin
            done_r <= stage1_r;
            if (stage1_r) begin
                cur2_r <= cur1_r;
                pwr_r <= calc_power(cur1_r, bus1_r);
            end
        end
    end

    assign sif.done = done_r;
    assign sif.cur = cur2_r;
    assign sif.pwr = pwr_r;

endmodule : scale_mac
`default_nettype wire

// File: hw/current_power_scaling_engine.sv
// Register bank and result scaling of the current and power monitor.
// What this block does
// - Current equals signed shunt code times scale factor, divided by 2048.
// - Power equals current result times bus voltage code, divided by 20000.
// - Current and power read zero until a scale factor is written.
// - After scale factor is written, each measurement refreshes current and power.
// - Bus voltage result weights 1.25 mV per step, independent of scale factor.
// - Bus voltage result always reads zero in its top bit.
// - One power step is worth exactly 25 current steps, fixed internally.
`timescale 1ns/1ns
`default_nettype none
module current_power_scaling_engine
    import cpse_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    input wire logic i_meas_valid,
    input wire logic [15:0] i_shunt_code,
    input wire logic [15:0] i_bus_code,
    output logic [15:0] o_setup,
    output logic o_scale_set
);
    logic [15:0] operating_setup_r;
    logic [15:0] shunt_voltage_result_r;
    logic [15:0] bus_voltage_result_r;
    logic [15:0] power_result_r;
    logic [15:0] current_result_r;
    logic [15:0] scale_factor_r;
    logic scale_set_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic soft_reset;
    logic wr_setup;
    logic wr_scale;

    scale_if sif();

    assign wr_setup = i_reg_wr && (i_reg_addr == ADDR_SETUP);
    assign wr_scale = i_reg_wr && (i_reg_addr == ADDR_SCALE);
    assign soft_reset = wr_setup && i_reg_wdata[SETUP_RESET_BIT];

    // Operands are taken straight from the converter so the pipeline starts at once.
    assign sif.start = i_meas_valid && !soft_reset;
    assign sif.shunt = $signed(i_shunt_code);
    assign sif.bus = bus_field(i_bus_code);
    assign sif.scale = scale_factor_r;

    scale_mac u_scale_mac (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .sif(sif)
    );

    // Setup register; its reset bit returns every register to its default and self-clears.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || soft_reset) begin
            operating_setup_r <= SETUP_RST_VAL;
        end else if (wr_setup) begin
            operating_setup_r <= i_reg_wdata;
        end
    end

    // Scale factor and the flag that marks it as programmed.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || soft_reset) begin
            scale_factor_r <= SCALE_RST_VAL;
            scale_set_r <= 1'b0;
        end else if (wr_scale) begin
            scale_factor_r <= i_reg_wdata;
            scale_set_r <= 1'b1;
        end
    end

    // Raw measurement results.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || soft_reset) begin
            shunt_voltage_result_r <= RESULT_RST_VAL;
            bus_voltage_result_r <= RESULT_RST_VAL;
        end else if (i_meas_valid) begin
            shunt_voltage_result_r <= i_shunt_code;
            bus_voltage_result_r <= bus_field(i_bus_code);
        end
    end

    // Scaled results are held at zero until the scale factor has been written.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || soft_reset || !scale_set_r) begin
            current_result_r <= RESULT_RST_VAL;
            power_result_r <= RESULT_RST_VAL;
        end else if (sif.done) begin
            current_result_r <= sif.cur;
            power_result_r <= sif.pwr;
        end
    end

    // Read data follows the pointer with one cycle of latency; unmapped pointers read zero.
    always_comb begin
        case (i_reg_addr)
            ADDR_SETUP: rdata_nxt = operating_setup_r;
            ADDR_SHUNT: rdata_nxt = shunt_voltage_result_r;
            ADDR_BUS: rdata_nxt = bus_voltage_result_r;
            ADDR_POWER: rdata_nxt = power_result_r;
            ADDR_CURRENT: rdata_nxt = current_result_r;
            ADDR_SCALE: rdata_nxt = scale_factor_r;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_setup = operating_setup_r;
    assign o_scale_set = scale_set_r;

    AST_CURRENT_CALC: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_meas_valid && !soft_reset && scale_set_r) ##1 (scale_set_r && !soft_reset)[*2]
        |=> current_result_r == calc_current($past(i_shunt_code, 3),
                                             $past(scale_factor_r, 3)))
        else $error("Current result does not match shunt times scale over 2048.");

    AST_POWER_CALC: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_meas_valid && !soft_reset && scale_set_r) ##1 (scale_set_r && !soft_reset)[*2]
        |=> power_result_r == calc_power($signed(current_result_r),
                                         bus_field($past(i_bus_code, 3))))
        else $error("Power result does not match current times bus over 20000.");

    AST_HOLD_ZERO: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        !scale_set_r ##1 !scale_set_r |-> (current_result_r == 16'h0000)
                                          && (power_result_r == 16'h0000))
        else $error("Scaled results are not zero before the scale factor is written.");

    AST_REFRESH: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_meas_valid && !soft_reset && scale_set_r) |-> ##2 sif.done)
        else $error("A measurement did not refresh the scaled results in time.");

    AST_BUS_CAPTURE: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_meas_valid && !soft_reset)
        |=> bus_voltage_result_r[BUS_SIGN_BIT-1:0] == $past(i_bus_code[BUS_SIGN_BIT-1:0]))
        else $error("Bus result is not the converter code at fixed weighting.");

    AST_BUS_MSB: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        !bus_voltage_result_r[BUS_SIGN_BIT] && !(sif.bus[BUS_SIGN_BIT]))
        else $error("Bus result top bit is set.");

    AST_POWER_RATIO: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (sif.done && !sif.cur[15] && !sif.pwr[15])
        |-> longint'(sif.pwr) * POWER_TO_CURRENT_RATIO * 64'sd1000000000
            <= longint'(sif.cur) * longint'($past(sif.bus, 2)) * BUS_STEP_NV)
        else $error("Power to current step ratio broken.");

    AST_TRUNCATE: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (sif.done && !sif.cur[15] && !sif.pwr[15])
        |-> ($signed({{17{sif.pwr[15]}}, sif.pwr}) * POWER_DIVISOR
             <= sif.cur * $signed({1'b0, $past(sif.bus, 2)})))
        else $error("Power division rounds up instead of dropping the fraction.");

    AST_SHUNT_CAPTURE: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_meas_valid && !soft_reset) |=> shunt_voltage_result_r == $past(i_shunt_code))
        else $error("Shunt result does not hold the signed converter code.");

    AST_SOFT_RESET: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        soft_reset |=> (operating_setup_r == SETUP_RST_VAL) && !scale_set_r
                       && (scale_factor_r == SCALE_RST_VAL))
        else $error("Setup reset bit did not restore defaults.");

    // A setup reset also clears every measurement and scaled result.
    AST_SOFT_CLEAR: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        soft_reset |=> (shunt_voltage_result_r == 16'h0000)
                       && (bus_voltage_result_r == 16'h0000)
                       && (current_result_r == 16'h0000)
                       && (power_result_r == 16'h0000))
        else $error("Setup reset bit did not clear the results.");

    // The reset bit never reads back as set.
    AST_SETUP_SELF_CLEAR: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        !operating_setup_r[SETUP_RESET_BIT])
        else $error("Setup reset bit did not clear itself.");

    // Without a programmed scale factor the next results are zero.
    AST_UNSET_CLEARS: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        !scale_set_r |=> (current_result_r == 16'h0000) && (power_result_r == 16'h0000))
        else $error("Scaled results are not cleared while the scale factor is unset.");

    // A write to the scale factor stores it and marks it as programmed.
    AST_SCALE_WRITE: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        wr_scale |=> scale_set_r && (scale_factor_r == $past(i_reg_wdata)))
        else $error("Scale factor write was not taken.");

    // Once programmed, the flag stays until a reset.
    AST_SCALE_STICKY: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (scale_set_r && !soft_reset) |=> scale_set_r)
        else $error("Scale programmed flag dropped without a reset.");

    // Scaled results change only when the pipeline delivers or a setup reset clears them.
    AST_CURRENT_HOLD: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!sif.done && !soft_reset && scale_set_r) |=> $stable(current_result_r))
        else $error("Current result changed without a new measurement.");

    AST_POWER_HOLD: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!sif.done && !soft_reset && scale_set_r) |=> $stable(power_result_r))
        else $error("Power result changed without a new measurement.");

    // Every accepted measurement leaves the pipeline two cycles later.
    AST_PIPE_DONE: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        sif.start |-> ##2 sif.done)
        else $error("Pipeline lost a measurement.");

    AST_PIPE_ORIGIN: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        sif.done |-> $past(sif.start, 2))
        else $error("Pipeline delivered a result nobody started.");

    // Zero operands give zero products.
    AST_ZERO_SCALE: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (sif.start && sif.scale == 16'h0000)
        |-> ##2 (sif.cur == 16'sh0000) && (sif.pwr == 16'sh0000))
        else $error("Zero scale factor gave a nonzero current.");

    AST_ZERO_SHUNT: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (sif.start && sif.shunt == 16'sh0000)
        |-> ##2 (sif.cur == 16'sh0000) && (sif.pwr == 16'sh0000))
        else $error("Zero shunt code gave a nonzero current.");

    AST_ZERO_BUS: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (sif.start && sif.bus == 16'h0000) |-> ##2 (sif.pwr == 16'sh0000))
        else $error("Zero bus code gave a nonzero power.");

    // A non-negative current never exceeds the exact quotient.
    AST_CURRENT_TRUNCATE: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (sif.done && !sif.cur[15] && !$past(sif.shunt[15], 2))
        |-> ($signed({17'h00000, sif.cur}) * CURRENT_DIVISOR
             <= $past(sif.shunt, 2) * $signed({1'b0, $past(sif.scale, 2)})))
        else $error("Current division rounds up instead of dropping the fraction.");

    // Writes to result registers are ignored.
    AST_SHUNT_READ_ONLY: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == ADDR_SHUNT && !i_meas_valid)
        |=> $stable(shunt_voltage_result_r))
        else $error("Shunt result was overwritten by the host.");

    AST_BUS_READ_ONLY: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_addr == ADDR_BUS && !i_meas_valid)
        |=> $stable(bus_voltage_result_r))
        else $error("Bus result was overwritten by the host.");

    // Read data presents the addressed result one cycle later.
    AST_READ_CURRENT: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_addr == ADDR_CURRENT) |=> o_reg_rdata == $past(current_result_r))
        else $error("Current result read back wrongly.");

    AST_READ_POWER: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_addr == ADDR_POWER) |=> o_reg_rdata == $past(power_result_r))
        else $error("Power result read back wrongly.");

    AST_READ_BUS: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_addr == ADDR_BUS) |=> !o_reg_rdata[BUS_SIGN_BIT])
        else $error("Bus result read back with its top bit set.");

    AST_READ_SHUNT: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_reg_addr == ADDR_SHUNT) |=> o_reg_rdata == $past(shunt_voltage_result_r))
        else $error("Shunt result read back wrongly.");

endmodule : current_power_scaling_engine
`default_nettype wire

// File: tb/host_model.sv
// Host processor model that programs and reads the engine registers.
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic i_mclk,
    input wire logic [15:0] i_reg_rdata,
    output logic [7:0] o_reg_addr,
    output logic o_reg_wr,
    output logic [15:0] o_reg_wdata
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        o_reg_addr <= a;
        o_reg_wr <= 1'b1;
        o_reg_wdata <= d;
        @(posedge i_mclk);
        o_reg_wr <= 1'b0;
        o_reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        o_reg_addr <= a;
        repeat (2) @(posedge i_mclk);
        #1 d = i_reg_rdata;
    endtask : rd
    // Scale factor from full-scale current in uA and resistance in mOhm.
    function automatic logic [15:0] cal_for(input int max_ua, input int r_mohm);
        int step;
        step = ((max_ua + 32767) / 32768 + 999) / 1000 * 1000;
        return 16'(5120000 / (step * r_mohm));
    endfunction : cal_for
    // Trimmed scale factor from a measured and a reported current.
    function automatic logic [15:0] trim(input logic [15:0] c, input int meas, input int rep);
        return 16'(int'(c) * meas / rep);
    endfunction : trim
endmodule : host_model
`default_nettype wire

// File: tb/test_current_power_scaling_engine.sv
// Self-checking bench for the current and power scaling engine.
`timescale 1ns/1ns
`default_nettype none
module test_current_power_scaling_engine;
    import cpse_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic mv = 1'b0;
    logic [15:0] sh = 16'h0000;
    logic [15:0] bu = 16'h0000;
    logic [7:0] addr;
    logic wr;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [15:0] setup;
    logic scl_set;
    logic [15:0] cal;
    int error_cnt = 0;
    int cmp_count = 0;
    always #4 i_mclk = ~i_mclk;
    host_model u_host (.i_mclk(i_mclk), .i_reg_rdata(rd), .o_reg_addr(addr), .o_reg_wr(wr),
        .o_reg_wdata(wd));
    current_power_scaling_engine uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wd), .o_reg_rdata(rd), .i_meas_valid(mv),
        .i_shunt_code(sh), .i_bus_code(bu), .o_setup(setup), .o_scale_set(scl_set));
    function automatic logic [15:0] e_cur(input logic [15:0] s, input logic [15:0] c);
        return 16'($signed(s) * int'(c) / 2048);
    endfunction : e_cur
    function automatic logic [15:0] e_pwr(input logic [15:0] i, input logic [15:0] b);
        return 16'($signed(i) * int'(b[14:0]) / 20000);
    endfunction : e_pwr
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        u_host.rd(a, d);
        chk(d, exp);
    endtask : rchk
    task automatic meas(input logic [15:0] s, input logic [15:0] b);
        @(posedge i_mclk);
        mv <= 1'b1;
        sh <= s;
        bu <= b;
        @(posedge i_mclk);
        mv <= 1'b0;
        sh <= ~s;
        bu <= ~b;
        repeat (4) @(posedge i_mclk);
    endtask : meas
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic t_reset;
        rchk(ADDR_SETUP, 16'h4127);
        chk(setup, 16'h4127);
        for (int a = 1; a < 10; a++) begin
            rchk(8'(a), 16'h0000);
        end
        $display("test reset done");
    endtask : t_reset
    task automatic t_uncal;
        meas(16'h1F40, 16'h2570);
        rchk(ADDR_SHUNT, 16'h1F40);
        rchk(ADDR_BUS, 16'h2570);
        rchk(ADDR_CURRENT, 16'h0000);
        rchk(ADDR_POWER, 16'h0000);
        chk({15'h0000, scl_set}, 16'h0000);
        $display("test uncalibrated done");
    endtask : t_uncal
    task automatic t_example;
        cal = u_host.cal_for(15000000, 2);
        u_host.wr(ADDR_SCALE, cal);
        rchk(ADDR_SCALE, cal);
        chk({15'h0000, scl_set}, 16'h0001);
        meas(16'h1F40, 16'hA570);
        rchk(ADDR_BUS, 16'h2570);
        rchk(ADDR_CURRENT, e_cur(16'h1F40, cal));
        rchk(ADDR_POWER, e_pwr(e_cur(16'h1F40, cal), 16'h2570));
        $display("test example done");
    endtask : t_example
    task automatic t_signs;
        logic [15:0] tab [3] = '{16'hE0C0, 16'h0003, 16'hFFFD};
        foreach (tab[k]) begin
            meas(tab[k], 16'h4E21);
            rchk(ADDR_CURRENT, e_cur(tab[k], cal));
            rchk(ADDR_POWER, e_pwr(e_cur(tab[k], cal), 16'h4E21));
        end
        $display("test truncation done");
    endtask : t_signs
    task automatic t_stream;
        u_host.wr(ADDR_CURRENT, 16'hFFFF);
        u_host.wr(ADDR_SHUNT, 16'hFFFF);
        rchk(ADDR_SHUNT, 16'hFFFD);
        rchk(ADDR_CURRENT, e_cur(16'hFFFD, cal));
        @(posedge i_mclk);
        mv <= 1'b1;
        sh <= 16'h1000;
        bu <= 16'h1000;
        @(posedge i_mclk);
        sh <= 16'h2000;
        bu <= 16'h3000;
        @(posedge i_mclk);
        mv <= 1'b0;
        repeat (4) @(posedge i_mclk);
        rchk(ADDR_CURRENT, e_cur(16'h2000, cal));
        rchk(ADDR_POWER, e_pwr(e_cur(16'h2000, cal), 16'h3000));
        $display("test stream done");
    endtask : t_stream
    task automatic t_trim;
        cal = u_host.trim(cal, 10200, 10000);
        u_host.wr(ADDR_SCALE, cal);
        meas(16'h1F40, 16'h2570);
        rchk(ADDR_CURRENT, e_cur(16'h1F40, cal));
        rchk(ADDR_POWER, e_pwr(e_cur(16'h1F40, cal), 16'h2570));
        $display("test trim done");
    endtask : t_trim
    task automatic t_soft;
        u_host.wr(ADDR_SETUP, 16'h8000);
        rchk(ADDR_SETUP, 16'h4127);
        rchk(ADDR_SCALE, 16'h0000);
        meas(16'h1F40, 16'h2570);
        rchk(ADDR_SHUNT, 16'h1F40);
        rchk(ADDR_CURRENT, 16'h0000);
        chk({15'h0000, scl_set}, 16'h0000);
        $display("test soft reset done");
    endtask : t_soft
    initial begin
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_reset;
        t_uncal;
        t_example;
        t_signs;
        t_stream;
        t_trim;
        t_soft;
        close_out;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        error_cnt++;
        close_out;
    end
endmodule : test_current_power_scaling_engine
`default_nettype wire
